// >>> pcs_pkg.sv
// package: constants, layouts and carriers for the pcm slot/format block
package pcs_pkg;
    localparam int NUM_CH = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int ADR_W = 8;
    localparam int CNT_W = 11;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CHSEL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_SLOT = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0C;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CFG_LAW = 0;
    localparam int CFG_LINEAR = 1;
    localparam int CFG_SIG = 2;
    localparam int CFG_TXEDGE = 3;
    localparam int CFG_OFS_LO = 4;
    localparam int CFG_MCLK_SEL = 7;
    localparam int SLOT_ACTIVE = 7;
    localparam int TX_MASK_LO = 16;
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL = 1;
    localparam int ST_LOADED_LO = 2;
    localparam int ST_FRAMES_LO = 8;

    // ---------------------------------------------------------------
    // reset values and codes
    // ---------------------------------------------------------------
    localparam logic [3:0] CHSEL_RST = 4'h0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] SLOT_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] ALAW_INV = 8'h55;
    localparam logic [7:0] MULAW_INV = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_RST = 11'h000;

    // pin index in the synchroniser vector
    localparam int PIN_PCLK = 0;
    localparam int PIN_FS = 1;
    localparam int PIN_MCLK = 2;
    localparam int PIN_RX = 3;

    typedef struct packed {
        logic mclk_sel;
        logic [2:0] clk_ofs;
        logic tx_fall;
        logic sig_en;
        logic linear;
        logic mu_law;
    } pcs_cfg_s;

    typedef struct packed {
        logic [3:0] chmask;
        logic [15:0] data;
    } pcs_tx_item_s;
endpackage

// >>> pcs_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module pcs_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o = (count != (AW + 1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// >>> pcs_slot_fmt.sv
// channel select registers, pcm slot assigner and clock generation
// How it works
// - four channels, each with own select bit
// - all selected channels take the same write
// - select bits live in one read/write register
// - samples: 8-bit companded or 16-bit linear
// - 8-bit uses one slot (two on transmit with signaling on), linear two
// - companded law selectable, A-law or mu-law
// - programmable slots, highway 128 kHz to 8.192 MHz
// - transmit edge and clock-slot offset programmable
// - master clock source: highway clock or mclk
// - generate internal master clock and frame sync
// - slot assigner links highway to each channel
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ns
module pcs_slot_fmt (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pcs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pclk_i,
    input wire logic fs_i,
    input wire logic mclk_i,
    input wire logic pcm_rx_i,
    output logic pcm_tx_o,
    output logic pcm_tx_oe_o,
    output logic dsp_clk_en_o,
    output logic frame_sync_o
);
    import pcs_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // lowest selected channel, used for read-back
    function automatic logic [1:0] first_chan(input logic [3:0] m);
        logic [1:0] r;
        r = 2'd0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (m[c]) begin
                r = 2'(c);
            end
        end
        return r;
    endfunction

    // {hit, second slot, channel} for a highway slot
    function automatic logic [3:0] find_owner(input logic [6:0] slot,
            input logic [31:0] tab, input logic two);
        logic [3:0] r;
        logic [6:0] base;
        r = 4'h0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            base = tab[c*8 +: 7];
            if (tab[c*8 + SLOT_ACTIVE]) begin
                if (slot == base) begin
                    r = {2'b10, 2'(c)};
                end else if (two && slot == 7'(base + 7'd1)) begin
                    r = {2'b11, 2'(c)};
                end
            end
        end
        return r;
    endfunction

    // {valid, position} of a bit count after the clock-slot offset
    function automatic logic [CNT_W:0] slot_pos(input logic [CNT_W-1:0] n,
            input logic [2:0] ofs);
        return {n >= CNT_W'(ofs), CNT_W'(n - CNT_W'(ofs))};
    endfunction

    // line coding of a companded byte; self-inverse
    function automatic logic [7:0] law_code(input logic mu,
            input logic [7:0] b);
        return b ^ (mu ? MULAW_INV : ALAW_INV);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_lvl;
    logic [3:0] next_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    assign next_lvl = ((pin_s2 ~^ pin_s3) & pin_s3)
                    | ((pin_s2 ^ pin_s3) & pin_lvl);
    assign pin_rise = next_lvl & ~pin_lvl;
    assign pin_fall = ~next_lvl & pin_lvl;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
            pin_lvl <= 4'h0;
        end else begin
            pin_s1 <= {pcm_rx_i, mclk_i, fs_i, pclk_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_lvl <= next_lvl;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [3:0] chan_sel;
    pcs_cfg_s cfg;
    logic [7:0] slot_tab [NUM_CH];
    logic [31:0] slot_flat;
    logic [15:0] tx_word [NUM_CH];
    logic [15:0] frame_word [NUM_CH];
    logic [15:0] rx_word [NUM_CH];
    logic [3:0] tx_loaded;
    logic [7:0] frame_cnt;
    logic [1:0] sel_ch;
    logic wb_req;
    logic wr_ok;
    logic tx_push;
    logic push_ready;
    logic ack_now;
    logic fifo_empty_n;
    logic fifo_pop;
    pcs_tx_item_s push_item;
    pcs_tx_item_s pop_item;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            slot_flat[c*8 +: 8] = slot_tab[c];
        end
    end

    assign sel_ch = first_chan(chan_sel);
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ok = wb_req & wb_we_i & wb_sel_i[0];
    assign tx_push = wb_req & wb_we_i & (wb_adr_i == OFS_TXDATA);
    // a push into a full fifo holds the bus cycle until room frees
    assign ack_now = wb_req & (~tx_push | push_ready);
    assign push_item = '{chmask: chan_sel, data: wb_dat_i[15:0]};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= ack_now;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_sel <= CHSEL_RST;
            cfg <= CFG_RST;
        end else if (wr_ok) begin
            if (wb_adr_i == OFS_CHSEL) begin
                chan_sel <= wb_dat_i[3:0];
            end
            if (wb_adr_i == OFS_CFG) begin
                cfg <= wb_dat_i[7:0];
            end
        end
    end

    // slot programming reaches every selected channel at once
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                slot_tab[c] <= SLOT_RST;
            end
        end else if (wr_ok && wb_adr_i == OFS_SLOT) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (chan_sel[c]) begin
                    slot_tab[c] <= wb_dat_i[7:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ack_now) begin
            case (wb_adr_i)
                OFS_CHSEL: wb_dat_o <= {28'h000_0000, chan_sel};
                OFS_CFG: wb_dat_o <= {24'h00_0000, cfg};
                OFS_SLOT: wb_dat_o <= {24'h00_0000, slot_tab[sel_ch]};
                OFS_RXDATA: wb_dat_o <= {16'h0000, rx_word[sel_ch]};
                OFS_STATUS: begin
                    wb_dat_o <= 32'h0000_0000;
                    wb_dat_o[ST_EMPTY] <= ~fifo_empty_n;
                    wb_dat_o[ST_FULL] <= ~push_ready;
                    wb_dat_o[ST_LOADED_LO +: 4] <= tx_loaded;
                    wb_dat_o[ST_FRAMES_LO +: 8] <= frame_cnt;
                end
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // transmit sample buffering
    // ---------------------------------------------------------------
    pcs_fifo #(
        .WIDTH($bits(pcs_tx_item_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(tx_push),
        .in_ready_o(push_ready),
        .in_data_i(push_item),
        .out_valid_o(fifo_empty_n),
        .out_ready_i(fifo_pop),
        .out_data_o(pop_item)
    );

    // a word waits until every channel it targets has a free buffer
    assign fifo_pop = fifo_empty_n & ((pop_item.chmask & tx_loaded) == 4'h0);

    // ---------------------------------------------------------------
    // highway framing and clock generation
    // ---------------------------------------------------------------
    logic pclk_rise;
    logic pclk_fall;
    logic fs_rise;
    logic frame_pend;
    logic frame_start;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W:0] tx_pos;
    logic [CNT_W:0] rx_pos;
    logic [3:0] tx_own;
    logic [3:0] rx_own;
    logic [15:0] own_word;
    logic [7:0] tx_byte;
    logic tx_launch;
    logic [7:0] rx_shift;
    logic [7:0] rx_byte;

    assign pclk_rise = pin_rise[PIN_PCLK];
    assign pclk_fall = pin_fall[PIN_PCLK];
    assign fs_rise = pin_rise[PIN_FS];
    assign frame_start = pclk_rise & (frame_pend | fs_rise);
    assign next_cnt = frame_start ? CNT_RST : CNT_W'(bit_cnt + 1'b1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_pend <= 1'b0;
            bit_cnt <= CNT_RST;
            frame_cnt <= 8'h00;
        end else begin
            if (fs_rise && !pclk_rise) begin
                frame_pend <= 1'b1;
            end else if (pclk_rise) begin
                frame_pend <= 1'b0;
            end
            if (pclk_rise) begin
                bit_cnt <= next_cnt;
            end
            if (frame_start) begin
                frame_cnt <= frame_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dsp_clk_en_o <= 1'b0;
            frame_sync_o <= 1'b0;
        end else begin
            dsp_clk_en_o <= cfg.mclk_sel ? pin_rise[PIN_MCLK]
                                         : pclk_rise;
            frame_sync_o <= fs_rise;
        end
    end

    // ---------------------------------------------------------------
    // slot assigner: transmit
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_loaded <= 4'h0;
            for (int c = 0; c < NUM_CH; c++) begin
                tx_word[c] <= WORD_RST;
                frame_word[c] <= WORD_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (frame_start && tx_loaded[c]) begin
                    frame_word[c] <= tx_word[c];
                end
                if (fifo_pop && pop_item.chmask[c]) begin
                    tx_word[c] <= pop_item.data;
                end
            end
            tx_loaded <= (frame_start ? 4'h0 : tx_loaded)
                       | (fifo_pop ? pop_item.chmask : 4'h0);
        end
    end

    assign tx_launch = cfg.tx_fall ? pclk_fall : pclk_rise;
    assign tx_cnt = cfg.tx_fall ? bit_cnt : next_cnt;
    assign tx_pos = slot_pos(tx_cnt, cfg.clk_ofs);
    assign tx_own = find_owner(tx_pos[9:3], slot_flat,
                               cfg.linear | cfg.sig_en);
    assign own_word = frame_word[tx_own[1:0]];

    always_comb begin
        if (cfg.linear) begin
            tx_byte = tx_own[2] ? own_word[7:0] : own_word[15:8];
        end else if (tx_own[2]) begin
            tx_byte = own_word[15:8];
        end else begin
            tx_byte = law_code(cfg.mu_law, own_word[7:0]);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pcm_tx_o <= 1'b0;
            pcm_tx_oe_o <= 1'b0;
        end else if (tx_launch) begin
            pcm_tx_oe_o <= tx_pos[CNT_W] & tx_own[3];
            pcm_tx_o <= tx_byte[3'd7 - tx_pos[2:0]];
        end
    end

    // ---------------------------------------------------------------
    // slot assigner: receive, sampled on the falling highway edge
    // ---------------------------------------------------------------
    assign rx_pos = slot_pos(bit_cnt, cfg.clk_ofs);
    assign rx_own = find_owner(rx_pos[9:3], slot_flat, cfg.linear);
    assign rx_byte = {rx_shift[6:0], pin_lvl[PIN_RX]};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_shift <= 8'h00;
            for (int c = 0; c < NUM_CH; c++) begin
                rx_word[c] <= WORD_RST;
            end
        end else if (pclk_fall) begin
            rx_shift <= rx_byte;
            if (rx_pos[CNT_W] && rx_own[3] && rx_pos[2:0] == 3'd7) begin
                if (!cfg.linear) begin
                    rx_word[rx_own[1:0]] <= {8'h00,
                        law_code(cfg.mu_law, rx_byte)};
                end else if (rx_own[2]) begin
                    rx_word[rx_own[1:0]][7:0] <= rx_byte;
                end else begin
                    rx_word[rx_own[1:0]][15:8] <= rx_byte;
                end
            end
        end
    end
endmodule

// >>> pcs_slot_fmt_asserts.sv
// concurrent checks on the pcm slot/format block ports
`timescale 1ns/1ns
module pcs_slot_fmt_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pcs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pclk_i,
    input wire logic fs_i,
    input wire logic mclk_i,
    input wire logic pcm_rx_i,
    input wire logic pcm_tx_o,
    input wire logic pcm_tx_oe_o,
    input wire logic dsp_clk_en_o,
    input wire logic frame_sync_o
);
    import pcs_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i)
        && $past(wb_stb_i)) else $error("ack without request");
    a_ack_prompt: assert property ($rose(wb_stb_i) && wb_cyc_i
        && wb_adr_i != OFS_TXDATA |=> wb_ack_o)
        else $error("register access not answered next cycle");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i > OFS_STATUS |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (wb_ack_o
        |-> wb_dat_o[31:16] == 16'h0000) else $error("upper lanes set");
    a_chsel_width: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == OFS_CHSEL |-> wb_dat_o[31:4] == 28'h000_0000)
        else $error("select read wider than four channels");
    a_tick_pulse: assert property (dsp_clk_en_o |=> !dsp_clk_en_o)
        else $error("clock enable wider than one cycle");
    a_fsync_gap: assert property (frame_sync_o
        |=> !frame_sync_o [*8]) else $error("frame sync repeated");
    a_fsync_cause: assert property (frame_sync_o |-> $past(fs_i, 3)
        || $past(fs_i, 4) || $past(fs_i, 5))
        else $error("frame sync without frame pin");
    a_slot_whole: assert property ($rose(pcm_tx_oe_o)
        |=> pcm_tx_oe_o [*8]) else $error("slot drive cut short");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_tx: cover property ($rose(pcm_tx_oe_o));
    c_frame: cover property (frame_sync_o);
endmodule

bind pcs_slot_fmt pcs_slot_fmt_asserts pcs_slot_fmt_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pclk_i(pclk_i), .fs_i(fs_i), .mclk_i(mclk_i), .pcm_rx_i(pcm_rx_i),
    .pcm_tx_o(pcm_tx_o), .pcm_tx_oe_o(pcm_tx_oe_o),
    .dsp_clk_en_o(dsp_clk_en_o), .frame_sync_o(frame_sync_o));

// >>> pcs_hwy_model.sv
// highway master model: bit clock, frame sync, rx stream, tx capture
`timescale 1ns/1ns
module pcs_hwy_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic samp_rise_i,
    input wire logic [31:0] rx_word_i,
    input wire logic tx_i,
    input wire logic tx_oe_i,
    output logic pclk_o,
    output logic fs_o,
    output logic rx_o,
    output logic [31:0] frame_o,
    output logic [31:0] frame_oe_o,
    output logic [15:0] nfr_o
);
    logic [3:0] ph;
    logic [4:0] bit_n;
    logic [31:0] cap;
    logic [31:0] cap_oe;
    logic samp;
    assign samp = samp_rise_i ? (ph == 4'h8) : (ph == 4'h0);
    // bit clock is clk/16, 32 bits a frame, fs in the low half of bit 31
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph <= 4'h0;
            bit_n <= 5'h1E;
            pclk_o <= 1'b0;
            fs_o <= 1'b0;
            rx_o <= 1'b0;
        end else begin
            ph <= ph + 4'h1;
            pclk_o <= ph[3];
            fs_o <= (bit_n == 5'h1F) && !ph[3];
            if (ph == 4'h8) begin
                bit_n <= bit_n + 5'h1;
                rx_o <= rx_word_i[5'h1E - bit_n];
            end
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nfr_o <= 16'h0000;
        end else if (samp) begin
            // a released line reads as the inverse of what the pin holds
            cap[5'h1F - bit_n] <= tx_oe_i ? tx_i : ~tx_i;
            cap_oe[5'h1F - bit_n] <= tx_oe_i;
            if (bit_n == 5'h1F) begin
                frame_o <= {cap[31:1], tx_oe_i ? tx_i : ~tx_i};
                frame_oe_o <= {cap_oe[31:1], tx_oe_i};
                nfr_o <= nfr_o + 16'h0001;
            end
        end
    end
endmodule

// >>> tb_top.sv
// self-checking bench for the pcm slot/format block
`timescale 1ns/1ns
module tb_top;
    import pcs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic mclk = 1'b0;
    logic samp_rise = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] bsel = 4'hF;
    logic [2:0] mcnt = 3'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, frame, frame_oe;
    logic [15:0] nfr;
    logic ack, pclk, fs, rx, tx, tx_oe, clk_en, fsync;
    int n_fail = 0;
    int check_count = 0;

    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        mcnt <= (mcnt == 3'h4) ? 3'h0 : mcnt + 3'h1;
        if (mcnt == 3'h4) begin
            mclk <= ~mclk;
        end
    end

    pcs_slot_fmt pcs_slot_fmt_inst (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pclk_i(pclk), .fs_i(fs),
        .mclk_i(mclk), .pcm_rx_i(rx), .pcm_tx_o(tx), .pcm_tx_oe_o(tx_oe),
        .dsp_clk_en_o(clk_en), .frame_sync_o(fsync));
    pcs_hwy_model pcs_hwy_model_inst (
        .clk_i(clk), .rst_i(rst), .samp_rise_i(samp_rise),
        .rx_word_i(32'h0077_0000), .tx_i(tx), .tx_oe_i(tx_oe),
        .pclk_o(pclk), .fs_o(fs), .rx_o(rx), .frame_o(frame),
        .frame_oe_o(frame_oe), .nfr_o(nfr));

    task automatic end_of_test;
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e,
            input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", name, e, g);
        end
    endtask
    // single classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= bsel;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic frames(input int n);
        logic [15:0] t;
        t = nfr + 16'(n);
        while (nfr !== t) @(posedge clk);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        bus(1'b0, OFS_CHSEL, 32'h0000_0000, r);
        chk("chsel", 32'(CHSEL_RST), r);
        bus(1'b0, OFS_CFG, 32'h0000_0000, r);
        chk("cfg", 32'(CFG_RST), r);
        bus(1'b0, 8'h40, 32'h0000_0000, r);
        chk("unmapped", 32'h0000_0000, r);
        wr(OFS_CHSEL, 32'h0000_000A);
        bus(1'b0, OFS_CHSEL, 32'h0000_0000, r);
        chk("chsel readback", 32'h0000_000A, r);
        bsel = 4'hE;
        wr(OFS_CHSEL, 32'h0000_0005);
        bsel = 4'hF;
        bus(1'b0, OFS_CHSEL, 32'h0000_0000, r);
        chk("chsel lane off", 32'h0000_000A, r);
    endtask
    task automatic t_bcast;
        logic [31:0] r;
        wr(OFS_CHSEL, 32'h0000_000F);
        wr(OFS_SLOT, 32'h0000_0083);
        wr(OFS_CHSEL, 32'h0000_0002);
        wr(OFS_SLOT, 32'h0000_0005);
        for (int k = 0; k < NUM_CH; k++) begin
            wr(OFS_CHSEL, 32'(1 << k));
            bus(1'b0, OFS_SLOT, 32'h0000_0000, r);
            chk("slot", (k == 1) ? 32'h0000_0005 : 32'h0000_0083, r);
        end
        wr(OFS_CHSEL, 32'h0000_000F);
        wr(OFS_SLOT, 32'h0000_0000);
    endtask
    // law, linear, signaling byte, bit offset, falling launch edge
    task automatic t_formats;
        logic [7:0] cf [6];
        logic [15:0] dt [6];
        logic [31:0] ex [6];
        logic [31:0] mk [6];
        logic [31:0] a0;
        a0 = {8'h00, 8'hA5 ^ ALAW_INV, 16'h0000};
        cf = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h30, 8'h08};
        dt = '{16'h00A5, 16'h00A5, 16'h1234, 16'h3CA5, 16'h00A5, 16'h00A5};
        ex = '{a0, {8'h00, 8'hA5 ^ MULAW_INV, 16'h0000}, 32'h0012_3400,
            a0 | 32'h0000_3C00, a0 >> 3, a0};
        mk = '{32'h00FF_0000, 32'h00FF_0000, 32'h00FF_FF00, 32'h00FF_FF00,
            32'h001F_E000, 32'h00FF_0000};
        wr(OFS_CHSEL, 32'h0000_0001);
        wr(OFS_SLOT, 32'h0000_0081);
        for (int i = 0; i < 6; i++) begin
            samp_rise <= cf[i][CFG_TXEDGE];
            wr(OFS_CFG, 32'(cf[i]));
            wr(OFS_TXDATA, 32'(dt[i]));
            frames(4);
            chk("tx data", ex[i], frame & frame_oe);
            chk("tx enable", mk[i], frame_oe);
        end
    endtask
    task automatic t_fifo;
        logic [31:0] r;
        samp_rise <= 1'b0;
        wr(OFS_CFG, 32'h0000_0000);
        frames(1);
        repeat (32) @(posedge clk);
        for (int i = 1; i <= 5; i++) wr(OFS_TXDATA, 32'(i));
        bus(1'b0, OFS_STATUS, 32'h0000_0000, r);
        chk("fifo full", 32'h0000_0002, r & 32'h0000_0003);
        wr(OFS_TXDATA, 32'h0000_0006);
        frames(10);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, r);
        chk("fifo empty", 32'h0000_0001, r & 32'h0000_0003);
        chk("last word", {8'h00, 8'h06 ^ ALAW_INV, 16'h0000},
            frame & frame_oe);
        chk("last enable", 32'h00FF_0000, frame_oe);
    endtask
    task automatic t_rx;
        logic [31:0] r;
        frames(3);
        bus(1'b0, OFS_RXDATA, 32'h0000_0000, r);
        chk("rx byte", 32'(8'h77 ^ ALAW_INV), r & 32'h0000_00FF);
        wr(OFS_CFG, 32'h0000_0002);
        frames(3);
        bus(1'b0, OFS_RXDATA, 32'h0000_0000, r);
        chk("rx linear", 32'h0000_7700, r);
    endtask
    task automatic t_clk;
        int n;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CFG, (m == 1) ? 32'h0000_0080 : 32'h0000_0000);
            repeat (16) @(posedge clk);
            n = 0;
            repeat (320) begin
                @(posedge clk);
                n += int'(clk_en);
            end
            chk("ticks", (m == 1) ? 32'h0000_0020 : 32'h0000_0014, 32'(n));
        end
        n = 0;
        repeat (2048) begin
            @(posedge clk);
            n += int'(fsync);
        end
        chk("frame syncs", 32'h0000_0004, 32'(n));
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset;
        t_bcast;
        t_formats;
        t_fifo;
        t_rx;
        t_clk;
        end_of_test;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
endmodule
